// ---- rtl/pas_ctrl.sv ----
// phase alignment search controller: config registers, search and track
// assumes byte register writes from the serial core and one measured
// phase per meas_valid pulse, taken at the current delay_code
//
// Contract
// - accuracy 0 allows two codes, 1 exact
// - search error: 0 halts, 1 restarts
// - track error: 0 continues, 1 resets
// - margin field times eight, default eleven
// - alternate until one side hits margin
// - both margins hit: alternate inside margin
// - search fails at delay range endpoint
// - duty bit 7 enables duty correction
// - mode: search+track, track, search, invalid
// - enable 0 manual, 1 automatic
`timescale 1ns/100ps
module pas_ctrl #(
  parameter int DW = 10,
  parameter int PW = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic phase_align_enable,
  input wire logic [1:0] mode,
  input wire logic [DW-1:0] manual_delay,
  input wire logic [PW-1:0] target_phase,
  input wire logic [PW-1:0] meas_phase,
  input wire logic meas_valid,
  output logic [7:0] reg_rdata,
  output logic [DW-1:0] delay_code,
  output logic search_locked,
  output logic search_failed,
  output logic dcc_enable,
  output logic factory_step_dir,
  output logic [5:0] factory_manual_trim
);
  // the largest margin of 248 codes must leave room below the top code
  if (DW < 9 || PW < 2) begin : g_bad_param
    $error("pas_ctrl: DW must be >= 9, PW >= 2");
  end

  localparam logic [DW-1:0] MAX_CODE = {DW{1'b1}};
  localparam logic [DW-1:0] MID_CODE = {1'b1, {(DW-1){1'b0}}};

  logic [7:0] search_ctrl_reg;
  logic [7:0] duty_ctrl_reg;
  pas_pkg::pas_state_t state_reg;
  logic [DW-1:0] up_ptr_reg;
  logic [DW-1:0] dn_ptr_reg;
  logic [DW-1:0] start_reg;
  logic dir_up_reg;
  logic inner_reg;

  // register writes; reads return zero for unmapped offsets
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      search_ctrl_reg <= pas_pkg::SEARCH_CTRL_RST;
      duty_ctrl_reg <= pas_pkg::DUTY_CTRL_RST;
    end else if (reg_wr) begin
      if (reg_addr == pas_pkg::REG_SEARCH_CTRL) search_ctrl_reg <= reg_wdata;
      if (reg_addr == pas_pkg::REG_DUTY_CTRL) duty_ctrl_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        pas_pkg::REG_SEARCH_CTRL: reg_rdata <= search_ctrl_reg;
        pas_pkg::REG_DUTY_CTRL: reg_rdata <= duty_ctrl_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dcc_enable <= 1'b0;
      factory_step_dir <= 1'b0;
      factory_manual_trim <= 6'h00;
    end else begin
      dcc_enable <= duty_ctrl_reg[pas_pkg::DCC_BIT];
      factory_step_dir <= duty_ctrl_reg[pas_pkg::STEP_DIR_BIT];
      factory_manual_trim <= duty_ctrl_reg[pas_pkg::TRIM_MSB:0];
    end
  end

  logic exact_mode;
  logic search_retry;
  logic track_reset;
  logic [DW-1:0] margin_codes;
  logic [DW-1:0] lim_lo;
  logic [DW-1:0] lim_hi;
  logic [PW-1:0] phase_diff;
  logic phase_match;
  logic up_stop;
  logic dn_stop;
  logic at_end;

  assign exact_mode = search_ctrl_reg[pas_pkg::ACC_BIT];
  assign search_retry = search_ctrl_reg[pas_pkg::SERR_BIT];
  assign track_reset = search_ctrl_reg[pas_pkg::TERR_BIT];
  assign margin_codes = DW'(search_ctrl_reg[pas_pkg::MARGIN_MSB:0]) *
                        DW'(pas_pkg::MARGIN_SCALE);
  // inner pass drops the margin so only the true endpoints bound it
  assign lim_lo = inner_reg ? '0 : margin_codes;
  assign lim_hi = inner_reg ? MAX_CODE : MAX_CODE - margin_codes;
  assign phase_diff = (meas_phase > target_phase) ? meas_phase - target_phase
                                                  : target_phase - meas_phase;
  assign phase_match = exact_mode ? (phase_diff == '0)
                                  : (phase_diff <= PW'(pas_pkg::LOOSE_TOL));
  assign up_stop = up_ptr_reg >= lim_hi;
  assign dn_stop = dn_ptr_reg <= lim_lo;
  assign at_end = (delay_code == '0) || (delay_code == MAX_CODE);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= pas_pkg::ST_IDLE;
      delay_code <= MID_CODE;
      up_ptr_reg <= MID_CODE;
      dn_ptr_reg <= MID_CODE;
      start_reg <= MID_CODE;
      dir_up_reg <= 1'b1;
      inner_reg <= 1'b0;
      search_locked <= 1'b0;
      search_failed <= 1'b0;
    end else if (!phase_align_enable) begin
      // manual operation follows the external delay setting
      state_reg <= pas_pkg::ST_IDLE;
      delay_code <= manual_delay;
      search_locked <= 1'b0;
      search_failed <= 1'b0;
      inner_reg <= 1'b0;
    end else begin
      case (state_reg)
        pas_pkg::ST_IDLE: begin
          search_locked <= 1'b0;
          if (mode == pas_pkg::MODE_SEARCH_TRACK || mode == pas_pkg::MODE_SEARCH_ONLY) begin
            state_reg <= pas_pkg::ST_SEARCH;
            up_ptr_reg <= delay_code;
            dn_ptr_reg <= delay_code;
            start_reg <= delay_code;
            dir_up_reg <= 1'b1;
            inner_reg <= 1'b0;
            search_failed <= 1'b0;
          end else if (mode == pas_pkg::MODE_TRACK_ONLY) begin
            state_reg <= pas_pkg::ST_TRACK;
          end
        end
        pas_pkg::ST_SEARCH: begin
          if (meas_valid) begin
            if (phase_match) begin
              search_locked <= 1'b1;
              state_reg <= (mode == pas_pkg::MODE_SEARCH_ONLY) ? pas_pkg::ST_HALT
                                                               : pas_pkg::ST_TRACK;
            end else if (at_end) begin
              search_failed <= 1'b1;
              if (search_retry) begin
                // restart from the original point, not the failed end
                delay_code <= start_reg;
                up_ptr_reg <= start_reg;
                dn_ptr_reg <= start_reg;
                dir_up_reg <= 1'b1;
                inner_reg <= 1'b0;
              end else begin
                state_reg <= pas_pkg::ST_HALT;
              end
            end else if (up_stop && dn_stop) begin
              inner_reg <= 1'b1;
            end else if (!up_stop && (dn_stop || dir_up_reg)) begin
              up_ptr_reg <= up_ptr_reg + 1'b1;
              delay_code <= up_ptr_reg + 1'b1;
              dir_up_reg <= 1'b0;
            end else begin
              dn_ptr_reg <= dn_ptr_reg - 1'b1;
              delay_code <= dn_ptr_reg - 1'b1;
              dir_up_reg <= 1'b1;
            end
          end
        end
        pas_pkg::ST_TRACK: begin
          if (meas_valid) begin
            if (phase_match) begin
              search_locked <= 1'b1;
            end else if (meas_phase > target_phase && delay_code != '0) begin
              delay_code <= delay_code - 1'b1;
            end else if (meas_phase < target_phase && delay_code != MAX_CODE) begin
              delay_code <= delay_code + 1'b1;
            end else begin
              // target lost at a range end
              search_locked <= 1'b0;
              if (track_reset) begin
                state_reg <= pas_pkg::ST_IDLE;
                delay_code <= MID_CODE;
              end
            end
          end
        end
        pas_pkg::ST_HALT: begin
          if (mode == pas_pkg::MODE_TRACK_ONLY) state_reg <= pas_pkg::ST_TRACK;
        end
        default: state_reg <= pas_pkg::ST_IDLE;
      endcase
    end
  end

  AST_EXACT_LOCK: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == pas_pkg::ST_SEARCH && phase_align_enable && meas_valid && exact_mode
     && meas_phase != target_phase) |=> !$rose(search_locked))
    else $error("locked on inexact phase in exact mode");
  AST_LOOSE_LOCK: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == pas_pkg::ST_SEARCH && phase_align_enable && meas_valid && !exact_mode
     && phase_diff <= PW'(2)) |=> search_locked)
    else $error("loose match within two codes did not lock");
  AST_STOP_ON_ERR: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == pas_pkg::ST_SEARCH && phase_align_enable && meas_valid && !phase_match
     && at_end && !search_retry) |=> state_reg == pas_pkg::ST_HALT && search_failed)
    else $error("search did not halt on error");
  AST_RETRY_ON_ERR: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == pas_pkg::ST_SEARCH && phase_align_enable && meas_valid && !phase_match
     && at_end && search_retry) |=> state_reg == pas_pkg::ST_SEARCH
     && delay_code == $past(start_reg))
    else $error("search did not restart on error");
  AST_TRACK_ERR: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == pas_pkg::ST_TRACK && phase_align_enable && meas_valid && !phase_match
     && at_end && ((meas_phase > target_phase) == (delay_code == '0)))
     |=> state_reg == ($past(track_reset) ? pas_pkg::ST_IDLE : pas_pkg::ST_TRACK))
    else $error("track error policy not followed");
  AST_MARGIN_RESET: assert property (@(posedge clk)
    $rose(rstn) |-> search_ctrl_reg[4:0] == 5'h0B && margin_codes == DW'(88))
    else $error("margin default wrong");
  AST_OUTWARD: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == pas_pkg::ST_SEARCH && phase_align_enable && !inner_reg)
     |-> delay_code >= dn_ptr_reg && delay_code <= up_ptr_reg
     && (dn_ptr_reg >= margin_codes || dn_ptr_reg == start_reg))
    else $error("search stepped into margin before both sides stopped");
  AST_FAIL_AT_END: assert property (@(posedge clk) disable iff (!rstn)
    $rose(search_failed) |-> $past(delay_code) == '0 || $past(delay_code) == MAX_CODE)
    else $error("search failed away from endpoint");
  AST_DCC: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == pas_pkg::REG_DUTY_CTRL) |=> ##1 dcc_enable == $past(reg_wdata[7], 2))
    else $error("duty correction enable does not follow bit 7");
  AST_MANUAL: assert property (@(posedge clk) disable iff (!rstn)
    !phase_align_enable |=> delay_code == $past(manual_delay) && state_reg == pas_pkg::ST_IDLE)
    else $error("manual mode does not follow manual delay");
  AST_INVALID_MODE: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == pas_pkg::ST_IDLE && phase_align_enable && mode == 2'h3)
     |=> state_reg == pas_pkg::ST_IDLE)
    else $error("invalid mode left idle");
endmodule

// ---- rtl/pas_pkg.sv ----
// constants for the phase alignment search controller
// assumes a byte-wide register port fed by the serial interface core
package pas_pkg;
  localparam logic [7:0] REG_SEARCH_CTRL = 8'h2F;
  localparam logic [7:0] REG_DUTY_CTRL = 8'h30;
  localparam logic [7:0] SEARCH_CTRL_RST = 8'h0B;
  localparam logic [7:0] DUTY_CTRL_RST = 8'h00;
  localparam int ACC_BIT = 7;
  localparam int SERR_BIT = 6;
  localparam int TERR_BIT = 5;
  localparam int MARGIN_MSB = 4;
  localparam int DCC_BIT = 7;
  localparam int STEP_DIR_BIT = 6;
  localparam int TRIM_MSB = 5;
  localparam int MARGIN_SCALE = 8;
  localparam int LOOSE_TOL = 2;
  localparam logic [1:0] MODE_SEARCH_TRACK = 2'h0;
  localparam logic [1:0] MODE_TRACK_ONLY = 2'h1;
  localparam logic [1:0] MODE_SEARCH_ONLY = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SEARCH = 2'h1,
    ST_TRACK = 2'h3,
    ST_HALT = 2'h2
  } pas_state_t;
endpackage

// ---- tb/tb_pas_ctrl.sv ----
// self-checking bench for the phase alignment search controller
// assumes DW 10, PW 4 and every input driven on the falling edge
`timescale 1ns/100ps
module tb_pas_ctrl;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic phase_align_enable = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [9:0] manual_delay = 10'h200;
  logic [3:0] target_phase = 4'hE;
  logic [3:0] meas_phase = 4'h0;
  logic meas_valid = 1'b0;
  logic [7:0] reg_rdata;
  logic [9:0] delay_code;
  logic search_locked;
  logic search_failed;
  logic dcc_enable;
  logic factory_step_dir;
  logic [5:0] factory_manual_trim;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int top_seen;
  logic [9:0] held;

  always #12.5 clk = ~clk;

  pas_ctrl u_pas_ctrl (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .phase_align_enable(phase_align_enable), .mode(mode),
    .manual_delay(manual_delay), .target_phase(target_phase), .meas_phase(meas_phase),
    .meas_valid(meas_valid), .reg_rdata(reg_rdata), .delay_code(delay_code),
    .search_locked(search_locked), .search_failed(search_failed), .dcc_enable(dcc_enable),
    .factory_step_dir(factory_step_dir), .factory_manual_trim(factory_manual_trim));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    repeat (2) @(negedge clk);
    chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
  endtask

  // one measurement, then a spare cycle so the new code is settled
  task automatic meas(input logic [3:0] p);
    @(negedge clk);
    meas_phase = p;
    meas_valid = 1'b1;
    @(negedge clk);
    meas_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic start(input logic [1:0] m, input logic [9:0] d);
    phase_align_enable = 1'b0;
    mode = m;
    manual_delay = d;
    repeat (3) @(negedge clk);
    phase_align_enable = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  // ceiling well above the longest search sweep below
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      $display("MISMATCH run time expected end before 40000 cycles seen none");
      give_verdict();
    end
  end

  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    rd(8'h2F, 8'h0B);
    rd(8'h30, 8'h00);
    rd(8'h31, 8'h00);
    wr(8'h30, 8'h00);
    chk("trim", 16'h00, 16'(factory_manual_trim));
    chk("dcc", 16'h0, 16'(dcc_enable));
    wr(8'h30, 8'h80);
    chk("dcc", 16'h1, 16'(dcc_enable));
    chk("step_dir", 16'h0, 16'(factory_step_dir));
    rd(8'h30, 8'h80);
    wr(8'h2F, 8'h8B);
    rd(8'h2F, 8'h8B);
    $display("registers done");
    manual_delay = 10'h155;
    repeat (2) @(negedge clk);
    chk("manual delay", 16'h155, 16'(delay_code));
    start(2'h2, 10'h200);
    meas(4'hC);
    chk("delay", 16'h201, 16'(delay_code));
    meas(4'h0);
    chk("delay", 16'h1FF, 16'(delay_code));
    meas(4'hE);
    chk("locked", 16'h1, 16'(search_locked));
    meas(4'h0);
    chk("halted delay", 16'h1FF, 16'(delay_code));
    wr(8'h2F, 8'h0B);
    start(2'h0, 10'h200);
    meas(4'hC);
    chk("loose lock", 16'h1, 16'(search_locked));
    // a loose window would swallow every step near a target of 14
    wr(8'h2F, 8'h8B);
    meas(4'hF);
    chk("track down", 16'h1FF, 16'(delay_code));
    meas(4'h0);
    chk("track up", 16'h200, 16'(delay_code));
    $display("search and track done");
    start(2'h1, 10'h000);
    meas(4'hF);
    chk("track keep", 16'h000, 16'(delay_code));
    chk("unlocked", 16'h0, 16'(search_locked));
    wr(8'h2F, 8'hAB);
    start(2'h1, 10'h000);
    meas(4'hF);
    chk("track reset", 16'h200, 16'(delay_code));
    start(2'h3, 10'h123);
    meas(4'h0);
    chk("invalid mode", 16'h123, 16'(delay_code));
    $display("track and modes done");
    wr(8'h2F, 8'h8B);
    start(2'h2, 10'h300);
    top_seen = 0;
    repeat (600) begin
      meas(4'h0);
      if (int'(delay_code) > top_seen) top_seen = int'(delay_code);
    end
    chk("upper margin", 16'h1, 16'(top_seen inside {[928:935]}));
    chk("one side only", 16'h1, 16'(delay_code < 10'h200));
    for (int i = 0; i < 1500 && search_failed !== 1'b1; i++) begin
      meas(4'h0);
      if (int'(delay_code) > top_seen) top_seen = int'(delay_code);
    end
    chk("failed", 16'h1, 16'(search_failed));
    chk("inner pass", 16'h1, 16'(top_seen > 935));
    chk("at endpoint", 16'h1, 16'(delay_code inside {10'h000, 10'h3FF}));
    held = delay_code;
    meas(4'h0);
    chk("stopped", {6'h00, held}, delay_code);
    wr(8'h2F, 8'hC0);
    start(2'h2, 10'h3FE);
    meas(4'h0);
    chk("delay", 16'h3FF, 16'(delay_code));
    meas(4'h0);
    chk("retry start", 16'h3FE, 16'(delay_code));
    $display("margin and errors done");
    give_verdict();
  end
endmodule
